// ### design/sfsr_top.sv
// strap-selected synthesizer control, system reset and pps logic
//
// How it works
// - strap code 111 switches the synthesized output off.
// - straps read one when open, zero when grounded.
// - 10/20 MHz reference codes map to the listed output ratios.
// - 15.36/19.2 MHz reference codes map to the listed output ratios.
// - output is an n/m multiple of the reference, such as 4/3 or 8/5.
// - software enables the output; lock follows within one second.
// - lock output rises once the output is stable; low acts as reset.
// - internal reset plus a full reset from the manual reset pin.
// - fixes withheld 35 s after power-on, 3 s after later resets.
// - raw and clean pps outputs, both rising on the second.
// - clean pps slowly steered onto the raw pps.
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "sfsr_consts.svh"
module sfsr_top
  import sfsr_pkg::*;
#(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned SYNTH_START_CYC = `SFSR_SYNTH_START_CYC,
  parameter int unsigned COLD_HOLD_CYC = `SFSR_COLD_HOLD_CYC,
  parameter int unsigned WARM_HOLD_CYC = `SFSR_WARM_HOLD_CYC,
  parameter int unsigned PPS_PERIOD_CYC = `SFSR_PPS_PERIOD_CYC,
  parameter int unsigned PPS_WIDTH_CYC = `SFSR_PPS_WIDTH_CYC
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // board pins
  input wire logic [2:0] freq_select_straps,
  input wire logic manual_reset_n,
  input wire logic synth_out_i,
  output logic synth_out_o,
  output logic synth_out_oe,
  output logic synth_locked,
  output logic fix_enable,
  // pulse per second
  input wire logic raw_pps_in,
  output logic raw_pps_out,
  output logic clean_pps
);

  localparam logic [31:0] START_LAST = 32'(SYNTH_START_CYC - 1);
  localparam logic [31:0] COLD_LOAD = 32'(COLD_HOLD_CYC);
  localparam logic [31:0] WARM_LOAD = 32'(WARM_HOLD_CYC);
  localparam logic [31:0] PPS_LAST = 32'(PPS_PERIOD_CYC - 1);
  localparam logic [31:0] PPS_HALF = 32'(PPS_PERIOD_CYC / 2);
  localparam logic [31:0] PPS_WIDTH = 32'(PPS_WIDTH_CYC);
  localparam logic [31:0] RST_LAST = 32'(`SFSR_RST_HOLD_CYC - 1);

  sfsr_top_s r;
  sfsr_top_s next_r;
  sfsr_syn_if syn_bus();

  logic acc_phase;
  logic wr_acc;
  logic sw_rst;
  logic raw_rise;
  logic synth_on;
  logic [7:0] ratio;
  logic [31:0] status_word;
  logic [31:0] pps_step;

  ////////////////////////////////////////////////////////////////////////
  // decode of bus and pins

  // one wait state: pready rises in the second access cycle
  assign acc_phase = psel && penable && !r.pready;
  assign wr_acc = acc_phase && pwrite && paddr == `SFSR_CTRL_OFS;
  assign sw_rst = wr_acc && pwdata[`SFSR_CTRL_SWRST];
  assign raw_rise = raw_pps_in && !r.raw_q;
  assign synth_on = r.state == SFSR_ST_RUN && r.sw_en &&
                    r.code != `SFSR_CODE_OFF;
  assign ratio = sfsr_ratio(r.ref_sel, r.code);

  // status view of the block's own state
  assign status_word = {23'h0, r.state != SFSR_ST_RUN, r.warm,
                        r.prog_mode, r.fix_ok, r.locked,
                        r.code == `SFSR_CODE_OFF, r.code};

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_r = r;
    pps_step = 32'h1;
    next_r.raw_q = raw_pps_in;
    next_r.raw_out = raw_pps_in;

    // apb register access
    next_r.pready = acc_phase;
    if (acc_phase) begin
      next_r.pslverr = 1'b0;
      next_r.prdata = 32'h0;
      unique case (paddr)
        `SFSR_CTRL_OFS: begin
          if (pwrite) begin
            next_r.ref_sel = pwdata[`SFSR_CTRL_REF_HI:`SFSR_CTRL_REF_LO];
            next_r.sw_en = pwdata[`SFSR_CTRL_SWEN];
          end else begin
            next_r.prdata = {29'h0, r.sw_en, r.ref_sel};
          end
        end
        `SFSR_STATUS_OFS: begin
          next_r.prdata = status_word;
        end
        `SFSR_PHASE_OFS: begin
          next_r.prdata = r.phase_err;
        end
        default: begin
          next_r.pslverr = 1'b1;
        end
      endcase
    end

    // reset sequencer
    unique case (r.state)
      SFSR_ST_RESET: begin
        next_r.rst_cnt = (r.rst_cnt == RST_LAST) ? r.rst_cnt
                                                 : r.rst_cnt + 32'h1;
        if (r.rst_cnt == RST_LAST && manual_reset_n) begin
          next_r.state = SFSR_ST_SAMPLE;
        end
      end
      SFSR_ST_SAMPLE: begin
        // straps and the shared pin are caught after release
        next_r.code = freq_select_straps;
        next_r.prog_mode = !synth_out_i;
        next_r.fix_cnt = r.warm ? WARM_LOAD : COLD_LOAD;
        next_r.warm = 1'b1;
        next_r.state = SFSR_ST_RUN;
      end
      SFSR_ST_RUN: begin
        if (r.fix_cnt != 32'h0) begin
          next_r.fix_cnt = r.fix_cnt - 32'h1;
        end
        next_r.fix_ok = r.fix_cnt == 32'h0;
      end
    endcase

    // lock indicator after the software start time
    if (!synth_on) begin
      next_r.start_cnt = 32'h0;
      next_r.locked = 1'b0;
    end else if (r.start_cnt == START_LAST) begin
      next_r.locked = 1'b1;
    end else begin
      next_r.start_cnt = r.start_cnt + 32'h1;
    end

    // clean pps: on each raw edge move one cycle toward it, so a large
    // offset needs many seconds; that slowness is the loop's intent
    if (raw_rise) begin
      next_r.phase_err = r.pps_cnt;
      if (r.pps_cnt != 32'h0 && r.pps_cnt < PPS_HALF) begin
        pps_step = 32'h0;
      end else if (r.pps_cnt != 32'h0) begin
        pps_step = 32'h2;
      end
    end
    next_r.pps_cnt = r.pps_cnt + pps_step;
    if (r.pps_cnt + pps_step > PPS_LAST) begin
      next_r.pps_cnt = r.pps_cnt + pps_step - 32'(PPS_PERIOD_CYC);
    end
    next_r.clean_pps = next_r.pps_cnt < PPS_WIDTH;

    // full system reset from pin or software wins over everything
    if (!manual_reset_n || sw_rst) begin
      next_r.state = SFSR_ST_RESET;
      next_r.rst_cnt = 32'h0;
      next_r.fix_ok = 1'b0;
      next_r.locked = 1'b0;
      next_r.start_cnt = 32'h0;
      {next_r.sw_en, next_r.ref_sel} = `SFSR_CTRL_RESET;
    end
    if (r.state != SFSR_ST_RUN) begin
      next_r.fix_ok = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register; power-on starts in reset, so it is a cold start

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // synthesizer

  assign syn_bus.enable = synth_on;
  assign syn_bus.mul = ratio[7:4];
  assign syn_bus.div = ratio[3:0];

  sfsr_synth u_synth (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .syn(syn_bus)
  );

  // outputs straight from flops
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign synth_out_o = syn_bus.level;
  assign synth_out_oe = syn_bus.oe;
  assign synth_locked = r.locked;
  assign fix_enable = r.fix_ok;
  assign raw_pps_out = r.raw_out;
  assign clean_pps = r.clean_pps;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  property p_off_code;
    @(posedge pclk) disable iff (!presetn)
      ce && r.code == `SFSR_CODE_OFF |=> !synth_out_oe;
  endproperty
  a_off_code: assert property (p_off_code)
    else $error("output driven with off code");

  property p_sample;
    @(posedge pclk) disable iff (!presetn)
      ce && r.state == SFSR_ST_SAMPLE |=>
        r.code == $past(freq_select_straps);
  endproperty
  a_sample: assert property (p_sample)
    else $error("strap code not taken at release");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      r.state == SFSR_ST_RUN && $past(r.state) == SFSR_ST_RUN |->
        $stable(r.code);
  endproperty
  a_hold: assert property (p_hold)
    else $error("strap code changed while running");

  property p_ratio;
    @(posedge pclk) disable iff (!presetn)
      r.ref_sel == 2'h0 && r.code == 3'h5 |->
        syn_bus.mul == 4'h4 && syn_bus.div == 4'h3;
  endproperty
  a_ratio: assert property (p_ratio)
    else $error("wrong ratio for 13.33 MHz");

  // lock drops the cycle after the output stops being wanted
  property p_lock_run;
    @(posedge pclk) disable iff (!presetn)
      ce && !synth_on |=> !synth_locked;
  endproperty
  a_lock_run: assert property (p_lock_run)
    else $error("lock shown while not running");

  property p_oe_reset;
    @(posedge pclk) disable iff (!presetn)
      ce && r.state != SFSR_ST_RUN |=> !synth_out_oe;
  endproperty
  a_oe_reset: assert property (p_oe_reset)
    else $error("output pin driven around reset");

  property p_manual;
    @(posedge pclk) disable iff (!presetn)
      ce && !manual_reset_n |=> r.state == SFSR_ST_RESET && !synth_locked;
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual reset not taken");

  property p_cold;
    @(posedge pclk) disable iff (!presetn)
      ce && manual_reset_n && !sw_rst && r.state == SFSR_ST_SAMPLE &&
        !r.warm |=> r.fix_cnt == COLD_LOAD && !fix_enable;
  endproperty
  a_cold: assert property (p_cold)
    else $error("cold hold not loaded");

  property p_pps;
    @(posedge pclk) disable iff (!presetn)
      ce && next_r.pps_cnt == 32'h0 |=> clean_pps;
  endproperty
  a_pps: assert property (p_pps)
    else $error("clean pps low at the second");

  property p_apb;
    @(posedge pclk) disable iff (!presetn)
      ce && psel && penable && !pready |=> pready;
  endproperty
  a_apb: assert property (p_apb)
    else $error("apb answer late");

  property p_warm;
    @(posedge pclk) disable iff (!presetn)
      ce && manual_reset_n && !sw_rst && r.state == SFSR_ST_SAMPLE &&
        r.warm |=> r.fix_cnt == WARM_LOAD && !fix_enable;
  endproperty
  a_warm: assert property (p_warm)
    else $error("warm hold not loaded");

  property p_lock_time;
    @(posedge pclk) disable iff (!presetn)
      ce && manual_reset_n && !sw_rst && synth_on &&
        r.start_cnt == START_LAST |=> synth_locked;
  endproperty
  a_lock_time: assert property (p_lock_time)
    else $error("lock late after enable");

  // a hold on an early clean edge must not also wrap the counter
  property p_steer;
    @(posedge pclk) disable iff (!presetn)
      ce && raw_rise && r.pps_cnt != 32'h0 && r.pps_cnt < PPS_HALF |=>
        r.pps_cnt == $past(r.pps_cnt);
  endproperty
  a_steer: assert property (p_steer)
    else $error("early clean pps not held back");

  property p_raw_out;
    @(posedge pclk) disable iff (!presetn)
      ce |=> raw_pps_out == $past(raw_pps_in);
  endproperty
  a_raw_out: assert property (p_raw_out)
    else $error("raw pps not passed through");

  property p_sw_reset;
    @(posedge pclk) disable iff (!presetn)
      ce && sw_rst |=>
        r.state == SFSR_ST_RESET && !r.sw_en && !synth_locked;
  endproperty
  a_sw_reset: assert property (p_sw_reset)
    else $error("software reset not taken");

  c_lock: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(synth_locked));
  c_fix: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(fix_enable));
  c_manual: cover property (@(posedge pclk) disable iff (!presetn)
    r.state == SFSR_ST_RUN && !manual_reset_n);
  c_steer: cover property (@(posedge pclk) disable iff (!presetn)
    raw_rise && r.pps_cnt != 32'h0);

endmodule

// ### design/sfsr_consts.svh
// offsets, field positions, reset values and timing counts of the block
`ifndef SFSR_CONSTS_SVH
`define SFSR_CONSTS_SVH

// clock rate of pclk, the oscillator-derived reference
`define SFSR_PCLK_HZ 40000000

// register byte offsets on the apb bus
`define SFSR_CTRL_OFS 8'h00
`define SFSR_STATUS_OFS 8'h04
`define SFSR_PHASE_OFS 8'h08

// control register fields
`define SFSR_CTRL_REF_LO 0
`define SFSR_CTRL_REF_HI 1
`define SFSR_CTRL_SWEN 2
`define SFSR_CTRL_SWRST 3
// value of {enable, ref_sel} after a system reset: output off
`define SFSR_CTRL_RESET 3'h0

// strap code that switches the synthesizer off
`define SFSR_CODE_OFF 3'h7

// times in their own units, then the cycle counts derived from them
`define SFSR_SYNTH_START_MS 1000
`define SFSR_COLD_HOLD_S 35
`define SFSR_WARM_HOLD_S 3
`define SFSR_PPS_PERIOD_S 1
`define SFSR_PPS_WIDTH_MS 100
`define SFSR_SYNTH_START_CYC (`SFSR_SYNTH_START_MS * (`SFSR_PCLK_HZ / 1000))
`define SFSR_COLD_HOLD_CYC (`SFSR_COLD_HOLD_S * `SFSR_PCLK_HZ)
`define SFSR_WARM_HOLD_CYC (`SFSR_WARM_HOLD_S * `SFSR_PCLK_HZ)
`define SFSR_PPS_PERIOD_CYC (`SFSR_PPS_PERIOD_S * `SFSR_PCLK_HZ)
`define SFSR_PPS_WIDTH_CYC (`SFSR_PPS_WIDTH_MS * (`SFSR_PCLK_HZ / 1000))

// cycles the internal system reset is held after its cause goes away
`define SFSR_RST_HOLD_CYC 16

// synthesizer phase accumulator: threshold is div shifted by this
`define SFSR_ACC_SHIFT 3

`endif

// ### design/sfsr_pkg.sv
// types and the ratio decoder shared by the block's modules
package sfsr_pkg;

  // sequencing of the internal system reset
  typedef enum logic [1:0] {
    SFSR_ST_RESET,
    SFSR_ST_SAMPLE,
    SFSR_ST_RUN
  } sfsr_state_e;

  // whole state of the top module
  typedef struct packed {
    sfsr_state_e state;
    logic [31:0] rst_cnt;
    logic warm;
    logic [2:0] code;
    logic prog_mode;
    logic [1:0] ref_sel;
    logic sw_en;
    logic [31:0] fix_cnt;
    logic fix_ok;
    logic [31:0] start_cnt;
    logic locked;
    logic [31:0] pps_cnt;
    logic clean_pps;
    logic raw_q;
    logic raw_out;
    logic [31:0] phase_err;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } sfsr_top_s;

  // whole state of the synthesizer
  typedef struct packed {
    logic [7:0] acc;
    logic level;
    logic oe;
  } sfsr_syn_s;

  // multiplier and divider for a strap code and a reference choice;
  // ref_sel 0:10 MHz 1:15.36 MHz 2:19.2 MHz 3:20 MHz
  function automatic logic [7:0] sfsr_ratio(input logic [1:0] ref_sel,
                                            input logic [2:0] code);
    logic [7:0] r;
    r = 8'h11;
    unique case (ref_sel)
      2'h0: r = (code == 3'h6) ? 8'h12 : (code == 3'h5) ? 8'h43 :
                (code == 3'h4) ? 8'h85 : (code == 3'h3) ? 8'h21 :
                (code == 3'h2) ? 8'h83 : (code == 3'h1) ? 8'h41 : 8'h81;
      2'h1: r = (code == 3'h6) ? 8'h3A : (code == 3'h5) ? 8'h23 :
                (code == 3'h4) ? 8'h11 : (code == 3'h3) ? 8'h32 :
                (code == 3'h2) ? 8'h21 : (code == 3'h1) ? 8'h31 : 8'h61;
      2'h2: r = (code == 3'h6) ? 8'h14 : (code == 3'h5) ? 8'h12 :
                (code == 3'h4) ? 8'h23 : (code == 3'h3) ? 8'h45 :
                (code == 3'h2) ? 8'h43 : (code == 3'h1) ? 8'h21 : 8'h41;
      2'h3: r = (code == 3'h6) ? 8'h14 : (code == 3'h5) ? 8'h12 :
                (code == 3'h4) ? 8'h23 : (code == 3'h3) ? 8'h45 :
                (code == 3'h2) ? 8'h43 : (code == 3'h1) ? 8'h21 : 8'h41;
    endcase
    return r;
  endfunction

endpackage

// ### design/sfsr_syn_if.sv
// carrier between the sequencer and the synthesizer
`timescale 1ns/1ps
interface sfsr_syn_if;
  logic enable;
  logic [3:0] mul;
  logic [3:0] div;
  logic level;
  logic oe;
  modport ctl(output enable, output mul, output div,
              input level, input oe);
  modport syn(input enable, input mul, input div,
              output level, output oe);
endinterface

// ### design/sfsr_synth.sv
// n/m synthesizer built as a phase accumulator on the reference clock
`timescale 1ns/1ps
module sfsr_synth
  import sfsr_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // control and output
  sfsr_syn_if.syn syn
);
`include "sfsr_consts.svh"

  sfsr_syn_s r;
  sfsr_syn_s next_r;
  logic [7:0] thr;
  logic [7:0] sum;

  // the digital model runs at ref*mul/(div*16), a scaled copy of the
  // real n/m ratio, because logic cannot toggle above half its clock
  always_comb begin
    thr = {1'b0, syn.div, `SFSR_ACC_SHIFT'h0};
    sum = r.acc + {4'h0, syn.mul};
    next_r = r;
    next_r.oe = syn.enable;
    if (!syn.enable) begin
      next_r.acc = 8'h00;
      next_r.level = 1'b0;
    end else if (sum >= thr) begin
      next_r.acc = sum - thr;
      next_r.level = ~r.level;
    end else begin
      next_r.acc = sum;
    end
  end

  // register the state; ce low freezes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign syn.level = r.level;
  assign syn.oe = r.oe;

  // output only toggles while enabled
  property p_syn_quiet;
    @(posedge pclk) disable iff (!presetn)
      !syn.enable && ce |=> !r.level;
  endproperty
  a_syn_quiet: assert property (p_syn_quiet)
    else $error("synth output moves while disabled");

endmodule

// ### verification/sfsr_board.sv
// board-side model: strap resistors, reset switch, pin buffer, pps source
`timescale 1ns/1ps
module sfsr_board #(
  parameter int PERIOD = 100
) (
  // clock
  input wire logic pclk,
  // bench controls
  input wire logic [2:0] strap_gnd,
  input wire logic press,
  // board pins
  output logic [2:0] freq_select_straps,
  output logic manual_reset_n,
  input wire logic synth_out_o,
  input wire logic synth_out_oe,
  output logic synth_out_i,
  output logic raw_pps_in
);
  int cnt = 37;

  // a grounded strap reads 0, an open one floats up on its pull-up
  assign freq_select_straps = ~strap_gnd;
  // open-collector switch: only ever pulls low, pull-up otherwise
  assign manual_reset_n = press ? 1'b0 : 1'b1;
  // high-impedance gate, no pull-down: a released pin reads high
  assign synth_out_i = synth_out_oe ? synth_out_o : 1'b1;

  // receiver pulse, started off phase so the steering has work to do
  always @(posedge pclk) begin
    cnt <= (cnt + 1) % PERIOD;
  end
  assign raw_pps_in = (cnt < 5);
endmodule

// ### verification/sfsr_top_bench.sv
// self-checking bench for the strap-selected synthesizer control
`timescale 1ns/1ps
`include "sfsr_consts.svh"
module sfsr_top_bench;
  import sfsr_pkg::*;
  localparam int START = 20;
  localparam int COLD = 50;
  localparam int WARM = 10;
  localparam int PER = 100;
  localparam int WID = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er;
  logic press = 1'b0;
  logic ce = 1'b1;
  logic [2:0] strap_gnd = 3'h0;
  logic [2:0] straps;
  logic mrst_n, syn_i, syn_o, syn_oe, locked, fix_en;
  logic raw_in, raw_out, clean;
  int err_total = 0;
  int check_count = 0;
  // rising edges in 960 cycles for codes 6 down to 0, per reference
  int exp_edges [4][7] = '{'{30, 80, 96, 120, 160, 240, 480},
                           '{18, 40, 60, 90, 120, 180, 360},
                           '{15, 30, 40, 48, 80, 120, 240},
                           '{15, 30, 40, 48, 80, 120, 240}};

  always #12.5 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////
  sfsr_top #(.SYNTH_START_CYC(START), .COLD_HOLD_CYC(COLD),
    .WARM_HOLD_CYC(WARM), .PPS_PERIOD_CYC(PER), .PPS_WIDTH_CYC(WID)) u_dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .freq_select_straps(straps), .manual_reset_n(mrst_n),
    .synth_out_i(syn_i), .synth_out_o(syn_o), .synth_out_oe(syn_oe),
    .synth_locked(locked), .fix_enable(fix_en), .raw_pps_in(raw_in),
    .raw_pps_out(raw_out), .clean_pps(clean));

  sfsr_board #(.PERIOD(PER)) u_board (
    .pclk(pclk), .strap_gnd(strap_gnd), .press(press),
    .freq_select_straps(straps), .manual_reset_n(mrst_n),
    .synth_out_o(syn_o), .synth_out_oe(syn_oe), .synth_out_i(syn_i),
    .raw_pps_in(raw_in));

  ////////////////////////////////////////////////////////////////////////
  // verdict and end of run, also reached when a wait runs out
  task finish_test;
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp,
           input string what);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s saw %h want %h", $time, what, seen,
               exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // bounded wait for a design flag, counting edges until it is high
  task automatic wait_hi(ref logic s, input int lim, output int n);
    n = 0;
    while (s !== 1'b1) begin
      @(posedge pclk);
      n++;
      if (n > lim) begin
        chk(1'b0, 1'b1, "wait ran out");
        finish_test();
      end
    end
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk(1'b0, 1'b1, "apb answer missing");
      finish_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // first release: cold fix hold, open straps switch the output off
  task t_cold;
    int n;
    wait_hi(fix_en, 200, n);
    chk(n >= COLD + 15 && n <= COLD + 21, 1'b1, "cold hold");
    apb(1'b0, `SFSR_STATUS_OFS, 32'h0);
    chk(rd[3:0], 4'hF, "open straps");
    chk(rd[6], 1'b0, "pin released high");
    apb(1'b1, `SFSR_CTRL_OFS, 32'h4);
    tick(START + 10);
    chk(syn_oe, 1'b0, "off code drives");
    chk(locked, 1'b0, "off code locks");
    apb(1'b0, `SFSR_CTRL_OFS, 32'h0);
    chk(rd, 32'h4, "control readback");
    apb(1'b0, 8'h0C, 32'h0);
    chk(er, 1'b1, "unmapped read error");
    chk(rd, 32'h0, "unmapped read data");
  endtask

  // codes 6 down to 0 under every reference, rate measured by edge count
  task t_ratios;
    int n, e;
    logic prev;
    for (int r = 0; r < 4; r++) begin
      for (int c = 0; c < 7; c++) begin
        strap_gnd <= ~(3'(6 - c));
        apb(1'b1, `SFSR_CTRL_OFS, 32'h8);
        tick(20);
        apb(1'b1, `SFSR_CTRL_OFS, 32'h4 | 32'(r));
        chk(locked, 1'b0, "lock before stable");
        wait_hi(locked, 100, n);
        chk(n >= START - 2 && n <= START + 3, 1'b1, "lock time");
        chk(syn_oe, 1'b1, "output driven");
        e = 0;
        prev = syn_o;
        repeat (960) begin
          @(posedge pclk);
          if (syn_o === 1'b1 && prev === 1'b0) e++;
          prev = syn_o;
        end
        chk(e >= exp_edges[r][c] - 1 && e <= exp_edges[r][c] + 1, 1'b1,
            "output rate");
      end
    end
  endtask

  // straps moved in run are ignored, manual reset re-samples them
  task t_manual;
    int n;
    strap_gnd <= 3'h0;
    tick(5);
    apb(1'b0, `SFSR_STATUS_OFS, 32'h0);
    chk(rd[2:0], 3'h0, "code held in run");
    chk(syn_oe, 1'b1, "output kept in run");
    press <= 1'b1;
    tick(4);
    chk({locked, fix_en, syn_oe}, 3'h0, "manual reset");
    press <= 1'b0;
    wait_hi(fix_en, 200, n);
    chk(n >= WARM + 15 && n <= WARM + 22, 1'b1, "warm hold");
    apb(1'b0, `SFSR_STATUS_OFS, 32'h0);
    chk(rd[3:0], 4'hF, "code re-sampled");
  endtask

  // raw pulse passes with one cycle delay, clean pulse steered onto it;
  // edges, not levels, so a window opening mid-pulse cannot mislead
  task t_pps;
    int ir, ro, cr, w, tg;
    logic pr, pc, v;
    ir = -1;
    ro = -1;
    cr = -1;
    w = 0;
    tg = 0;
    pr = 1'b1;
    pc = 1'b1;
    tick(PER * 60);
    for (int i = 0; i < 2 * PER; i++) begin
      @(posedge pclk);
      if (ir < 0 && raw_in === 1'b1 && pr === 1'b0) ir = i;
      if (ro < 0 && raw_out === 1'b1 && ir >= 0) ro = i;
      if (cr < 0 && clean === 1'b1 && pc === 1'b0 && ir >= 0) cr = i;
      if (i < PER && clean === 1'b1) w++;
      pr = raw_in;
      pc = clean;
    end
    chk(ro - ir, 1, "raw pps delay");
    chk(w, WID, "clean width");
    chk(cr >= ir && cr - ir <= 3, 1'b1, "clean aligned");
    apb(1'b0, `SFSR_PHASE_OFS, 32'h0);
    chk(rd, 32'h0, "phase error settled");
    // ce low must freeze the clean pulse for longer than one period
    ce <= 1'b0;
    tick(2);
    v = clean;
    repeat (2 * PER) begin
      @(posedge pclk);
      if (clean !== v) tg++;
    end
    ce <= 1'b1;
    chk(tg, 0, "clean pps moved while frozen");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    tick(20);
    presetn <= 1'b1;
    t_cold();
    t_ratios();
    t_manual();
    t_pps();
    finish_test();
  end
endmodule
